// ==== rtl/cdsv_defs.svh ====
// Purpose: offsets, field positions, reset values and codes of the
//          codec processing and playback volume registers
// Assumes: included by bare name from every design file but the package
// Notes:   definitions only
`ifndef CDSV_DEFS_SVH
`define CDSV_DEFS_SVH

// register offsets on the control port
`define CDSV_OFF_RECSEL   8'h3D
`define CDSV_OFF_MODE     8'h3E
`define CDSV_OFF_PATH     8'h3F
`define CDSV_OFF_MUTE     8'h40
`define CDSV_OFF_GAIN     8'h41

// reset values
`define CDSV_RST_RECSEL   8'h04
`define CDSV_RST_MODE     8'h00
`define CDSV_RST_PATH     8'h14
`define CDSV_RST_MUTE     8'h0C
`define CDSV_RST_GAIN     8'h00
`define CDSV_RD_UNMAPPED  8'h00

// record block select field
`define CDSV_RECSEL_HI    4
`define CDSV_RECSEL_LO    0
`define CDSV_RECSEL_ENG   5'h00

// mode register bits
`define CDSV_MODE_REC_A   6
`define CDSV_MODE_REC_B   5
`define CDSV_MODE_REC_RUN 4
`define CDSV_MODE_PB_A    2
`define CDSV_MODE_PB_B    1
`define CDSV_MODE_PB_RUN  0

// playback path setup fields
`define CDSV_PATH_PWR     7
`define CDSV_PATH_SRC_HI  5
`define CDSV_PATH_SRC_LO  4
`define CDSV_PATH_STEP_HI 1
`define CDSV_PATH_STEP_LO 0

// mute bit
`define CDSV_MUTE_BIT     3

// gain step and zero sample
`define CDSV_GAIN_STEP    8'h01
`define CDSV_SAMPLE_ZERO  16'h0000

`endif

// ==== rtl/cdsv_pkg.sv ====
// Purpose: types shared by the codec register bank files
// Assumes: nothing
// Notes:   encodings match the register fields
`default_nettype none
package cdsv_pkg;

  // playback source selection
  typedef enum logic [1:0] {
    CDSV_SRC_OFF   = 2'b00,
    CDSV_SRC_LEFT  = 2'b01,
    CDSV_SRC_RIGHT = 2'b10,
    CDSV_SRC_AVG   = 2'b11
  } cdsv_src_t;

  // volume soft-step modes
  typedef enum logic [1:0] {
    CDSV_STEP_EACH = 2'b00,
    CDSV_STEP_TWO  = 2'b01,
    CDSV_STEP_NONE = 2'b10,
    CDSV_STEP_RSVD = 2'b11
  } cdsv_step_t;

endpackage : cdsv_pkg
`default_nettype wire

// ==== rtl/cdsv_gain_stepper.sv ====
// Purpose: moves the applied playback gain toward the written target
// Assumes: sample_tick is a one-cycle pulse per playback sample period
// Notes:   gain codes are two's complement half-decibel counts
`include "cdsv_defs.svh"
`default_nettype none
module cdsv_gain_stepper (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic [7:0] target,
  input  wire logic [1:0] step_mode,
  input  wire logic       sample_tick,
  // result
  output logic      [7:0] gain_q,
  output logic            stepping
);

  logic       half_q;    // alternate-sample phase
  logic       half_d;
  logic [7:0] gain_d;
  wire        immediate; // changes applied at once
  wire        step_en;   // stepping interval reached
  wire        go_up;     // target above applied gain

  // reserved code 11 is treated as immediate
  assign immediate = (step_mode == cdsv_pkg::CDSV_STEP_NONE) ||
                     (step_mode == cdsv_pkg::CDSV_STEP_RSVD);
  assign step_en = sample_tick &&
                   ((step_mode == cdsv_pkg::CDSV_STEP_EACH) ||
                    ((step_mode == cdsv_pkg::CDSV_STEP_TWO) && half_q));
  assign go_up    = $signed(target) > $signed(gain_q);
  assign stepping = (gain_q != target);

  // phase toggles each sample in two-sample mode
  assign half_d = (sample_tick && step_mode == cdsv_pkg::CDSV_STEP_TWO) ?
                  ~half_q : half_q;

  // next applied gain
  always_comb begin
    gain_d = gain_q;
    if (immediate) begin
      gain_d = target;
    end else if (step_en && stepping) begin
      gain_d = go_up ? gain_q + `CDSV_GAIN_STEP
                     : gain_q - `CDSV_GAIN_STEP;
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      gain_q <= `CDSV_RST_GAIN;
      half_q <= 1'b0;
    end else begin
      gain_q <= gain_d;
      half_q <= half_d;
    end
  end

endmodule : cdsv_gain_stepper
`default_nettype wire

// ==== rtl/cdsv_regs.sv ====
// Purpose: processing-block select, engine mode bits and playback
//          converter power, source, soft-step, mute and gain registers
// Assumes: synchronous register port, one access per cycle at most;
//          frame and sample strobes are one-cycle pulses
// Notes:   read data registered, one cycle after rd_en
`include "cdsv_defs.svh"
`default_nettype none

// Behaviour
// - record select zero uses engine, resets to four
// - only zero and listed nonzero record codes are valid
// - record engine condition bits A, B
// - playback engine condition bits A, B
// - record counter clears per frame unless bit4
// - playback counter clears per frame unless bit0
// - bit7 powers playback converter, reset off
// - source: off, left, right, average; reset left
// - soft-step every sample, two, or immediate
// - mute bit3, reset muted
// - gain is signed half-decibel count, reset 0
module cdsv_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  // datapath timing strobes
  input  wire logic        rec_frame_start,
  input  wire logic        pb_frame_start,
  input  wire logic        pb_sample_tick,
  // playback samples in
  input  wire logic [15:0] left_in,
  input  wire logic [15:0] right_in,
  // record processing control
  output logic             rec_use_engine,
  output logic      [4:0]  rec_block_sel,
  output logic             rec_sel_reserved,
  output logic             rec_cond_a,
  output logic             rec_cond_b,
  output logic             rec_ic_clear,
  // playback engine control
  output logic             pb_cond_a,
  output logic             pb_cond_b,
  output logic             pb_ic_clear,
  // playback converter
  output logic             dac_power_up,
  output logic      [1:0]  pb_source,
  output logic             pb_muted,
  output logic      [7:0]  pb_gain_target,
  output logic      [7:0]  pb_gain_applied,
  output logic             pb_gain_stepping,
  output logic      [15:0] pb_sample_out
);

  // stored registers
  logic [7:0]  recsel_q;     // record block select
  logic [7:0]  mode_q;       // engine mode bits
  logic [7:0]  path_q;       // playback path setup
  logic [7:0]  mute_q;       // playback mute control
  logic [7:0]  gain_q;       // playback gain target
  logic [7:0]  rdata_d;
  logic [7:0]  rdata_d_q;    // registered read data
  logic        rec_clr_q;    // record counter clear pulse
  logic        pb_clr_q;     // playback counter clear pulse
  logic [15:0] sample_q;     // mixed playback sample
  logic [15:0] sample_d;

  // address decode
  wire hit_recsel = (addr == `CDSV_OFF_RECSEL);
  wire hit_mode   = (addr == `CDSV_OFF_MODE);
  wire hit_path   = (addr == `CDSV_OFF_PATH);
  wire hit_mute   = (addr == `CDSV_OFF_MUTE);
  wire hit_gain   = (addr == `CDSV_OFF_GAIN);

  // validity of a record block code
  function automatic logic rec_code_ok(input logic [4:0] code);
    case (code)
      5'h00, 5'h04, 5'h05, 5'h06,
      5'h0A, 5'h0B, 5'h0C,
      5'h10, 5'h11, 5'h12: rec_code_ok = 1'b1;
      default:             rec_code_ok = 1'b0;
    endcase
  endfunction : rec_code_ok

  // field extraction
  wire [1:0]  src_w   = path_q[`CDSV_PATH_SRC_HI:`CDSV_PATH_SRC_LO];
  wire [1:0]  step_w  = path_q[`CDSV_PATH_STEP_HI:`CDSV_PATH_STEP_LO];
  wire        pwr_w   = path_q[`CDSV_PATH_PWR];
  wire        mute_w  = mute_q[`CDSV_MUTE_BIT];

  assign rec_block_sel  = recsel_q[`CDSV_RECSEL_HI:`CDSV_RECSEL_LO];
  assign rec_use_engine = (rec_block_sel == `CDSV_RECSEL_ENG);
  assign rec_sel_reserved = ~rec_code_ok(rec_block_sel);

  assign rec_cond_a = mode_q[`CDSV_MODE_REC_A];
  assign rec_cond_b = mode_q[`CDSV_MODE_REC_B];
  assign pb_cond_a  = mode_q[`CDSV_MODE_PB_A];
  assign pb_cond_b  = mode_q[`CDSV_MODE_PB_B];

  assign dac_power_up   = pwr_w;
  assign pb_source      = src_w;
  assign pb_muted       = mute_w;
  assign pb_gain_target = gain_q;
  assign rec_ic_clear   = rec_clr_q;
  assign pb_ic_clear    = pb_clr_q;
  assign pb_sample_out  = sample_q;
  assign rdata          = rdata_d_q;

  // sign-extended sum for averaging
  wire [16:0] sum_w = {left_in[15], left_in} + {right_in[15], right_in};

  // source selection, muted or powered down gives silence
  always_comb begin
    sample_d = sample_q;
    if (pb_sample_tick) begin
      if (!pwr_w || mute_w) begin
        sample_d = `CDSV_SAMPLE_ZERO;
      end else begin
        case (src_w)
          cdsv_pkg::CDSV_SRC_OFF:   sample_d = `CDSV_SAMPLE_ZERO;
          cdsv_pkg::CDSV_SRC_LEFT:  sample_d = left_in;
          cdsv_pkg::CDSV_SRC_RIGHT: sample_d = right_in;
          cdsv_pkg::CDSV_SRC_AVG:   sample_d = sum_w[16:1];
          default:                  sample_d = `CDSV_SAMPLE_ZERO;
        endcase
      end
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rdata_d = `CDSV_RD_UNMAPPED;
    if (hit_recsel) begin
      rdata_d = recsel_q;
    end else if (hit_mode) begin
      rdata_d = mode_q;
    end else if (hit_path) begin
      rdata_d = path_q;
    end else if (hit_mute) begin
      rdata_d = mute_q;
    end else if (hit_gain) begin
      rdata_d = gain_q;
    end
  end

  // registered read data, held until the next read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_d_q <= `CDSV_RD_UNMAPPED;
    end else if (rd_en) begin
      rdata_d_q <= rdata_d;
    end
  end

  // register writes, reserved bits stored as written
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      recsel_q <= `CDSV_RST_RECSEL;
      mode_q   <= `CDSV_RST_MODE;
      // power-down and left source at reset
      path_q   <= `CDSV_RST_PATH;
      mute_q   <= `CDSV_RST_MUTE;
      gain_q   <= `CDSV_RST_GAIN;
    end else if (wr_en) begin
      if (hit_recsel) recsel_q <= wdata;
      if (hit_mode)   mode_q   <= wdata;
      if (hit_path)   path_q   <= wdata;
      if (hit_mute)   mute_q   <= wdata;
      if (hit_gain)   gain_q   <= wdata;
    end
  end

  // instruction counter clear pulses
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rec_clr_q <= 1'b0;
      pb_clr_q  <= 1'b0;
    end else begin
      rec_clr_q <= rec_frame_start & ~mode_q[`CDSV_MODE_REC_RUN];
      pb_clr_q  <= pb_frame_start & ~mode_q[`CDSV_MODE_PB_RUN];
    end
  end

  // mixed sample register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sample_q <= `CDSV_SAMPLE_ZERO;
    end else begin
      sample_q <= sample_d;
    end
  end

  cdsv_gain_stepper u_stepper (
    .clk         (clk),
    .rst_b       (rst_b),
    .target      (gain_q),
    .step_mode   (step_w),
    .sample_tick (pb_sample_tick),
    .gain_q      (pb_gain_applied),
    .stepping    (pb_gain_stepping)
  );

endmodule : cdsv_regs
`default_nettype wire

// ==== bench/cdsv_regs_assertions.sv ====
// Purpose: port checks of the codec register bank
// Assumes: bound onto cdsv_regs, one clock
// Notes:   helper copies of run and step bits follow writes
`include "cdsv_defs.svh"
`default_nettype none
module cdsv_regs_chk (
  // clock, reset and register port
  input wire logic       clk, rst_b, wr_en,
  input wire logic [7:0] addr, wdata,
  // strobes
  input wire logic       rec_frame_start, pb_frame_start, pb_sample_tick,
  // watched outputs
  input wire logic       rec_use_engine, rec_sel_reserved, rec_cond_a,
  input wire logic       rec_cond_b, rec_ic_clear, pb_cond_a, pb_cond_b,
  input wire logic       pb_ic_clear, dac_power_up, pb_muted,
  input wire logic       pb_gain_stepping,
  input wire logic [4:0] rec_block_sel,
  input wire logic [1:0] pb_source,
  input wire logic [7:0] pb_gain_target, pb_gain_applied
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [1:0] run_q;  // record, playback run bits
  logic [1:0] step_q; // soft-step mode
  wire w_sel  = wr_en && addr == `CDSV_OFF_RECSEL;
  wire w_mode = wr_en && addr == `CDSV_OFF_MODE;
  wire w_path = wr_en && addr == `CDSV_OFF_PATH;
  wire w_gain = wr_en && addr == `CDSV_OFF_GAIN;
  // follow mode and path writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      run_q  <= 2'h0;
      step_q <= 2'h0;
    end else if (w_mode) begin
      run_q <= {wdata[4], wdata[0]};
    end else if (w_path) begin
      step_q <= wdata[1:0];
    end
  end
  property p_sel;
    w_sel |=> rec_block_sel == $past(wdata[4:0]) &&
      rec_use_engine == ($past(wdata[4:0]) == 5'h00);
  endproperty
  a_sel: assert property (p_sel) else $error("record select");
  property p_rsv;
    rec_sel_reserved == !(rec_block_sel inside {5'h00, 5'h04, 5'h05,
      5'h06, 5'h0A, 5'h0B, 5'h0C, 5'h10, 5'h11, 5'h12});
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag");
  property p_cond;
    w_mode |=> {rec_cond_a, rec_cond_b, pb_cond_a, pb_cond_b} ==
      {$past(wdata[6:5]), $past(wdata[2:1])};
  endproperty
  a_cond: assert property (p_cond) else $error("cond bits");
  property p_rclr;
    rec_ic_clear == $past(rec_frame_start && !run_q[1]);
  endproperty
  a_rclr: assert property (p_rclr) else $error("record clear");
  property p_pclr;
    pb_ic_clear == $past(pb_frame_start && !run_q[0]);
  endproperty
  a_pclr: assert property (p_pclr) else $error("playback clear");
  property p_path;
    w_path |=> dac_power_up == $past(wdata[7]) &&
      pb_source == $past(wdata[5:4]);
  endproperty
  a_path: assert property (p_path) else $error("path setup");
  property p_mute;
    wr_en && addr == `CDSV_OFF_MUTE |=> pb_muted == $past(wdata[3]);
  endproperty
  a_mute: assert property (p_mute) else $error("mute");
  property p_gain;
    w_gain |=> pb_gain_target == $past(wdata);
  endproperty
  a_gain: assert property (p_gain) else $error("gain target");
  property p_stp;
    pb_gain_stepping == (pb_gain_applied != pb_gain_target);
  endproperty
  a_stp: assert property (p_stp) else $error("stepping flag");
  property p_hold;
    !pb_gain_stepping && !w_gain |=> !pb_gain_stepping &&
      pb_gain_applied == $past(pb_gain_applied);
  endproperty
  a_hold: assert property (p_hold) else $error("gain hold");
  property p_imm;
    step_q[1] && pb_gain_stepping && !w_gain |=> !pb_gain_stepping;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate gain");
  property p_tick;
    step_q == 2'h0 && pb_sample_tick && pb_gain_stepping && !w_gain
      |=> pb_gain_applied - $past(pb_gain_applied) ==
      ($signed($past(pb_gain_target)) > $signed($past(pb_gain_applied))
      ? 8'h01 : 8'hFF);
  endproperty
  a_tick: assert property (p_tick) else $error("gain step");
  c_clr: cover property (rec_ic_clear && pb_ic_clear);
  c_tick: cover property (pb_sample_tick && pb_gain_stepping);
  c_eng: cover property (rec_use_engine);
endmodule : cdsv_regs_chk
`default_nettype wire

// ==== bench/codec_dsp_select_dac_volume_tb_top.sv ====
// Purpose: self-checking bench of the codec register bank
// Assumes: checker bound at the foot of this file
// Notes:   inputs change on rising edges by non-blocking assignment
`include "cdsv_defs.svh"
`default_nettype none
module codec_dsp_select_dac_volume_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, pb_gain_target;
  logic        rec_frame_start = 1'b0, pb_frame_start = 1'b0;
  logic        pb_sample_tick = 1'b0, rec_use_engine, rec_sel_reserved;
  logic [15:0] left_in = 16'h1234, right_in = 16'h0F00, pb_sample_out;
  logic        rec_cond_a, rec_cond_b, rec_ic_clear, pb_cond_a, pb_cond_b;
  logic        pb_ic_clear, dac_power_up, pb_muted, pb_gain_stepping;
  logic [4:0]  rec_block_sel;
  logic [1:0]  pb_source;
  logic [7:0]  pb_gain_applied;
  int          miscompares = 0, checked = 0;
  always #10 clk = ~clk;
  cdsv_regs dut (.clk, .rst_b, .wr_en, .rd_en, .addr, .wdata, .rdata,
    .rec_frame_start, .pb_frame_start, .pb_sample_tick, .left_in,
    .right_in, .rec_use_engine, .rec_block_sel, .rec_sel_reserved,
    .rec_cond_a, .rec_cond_b, .rec_ic_clear, .pb_cond_a, .pb_cond_b,
    .pb_ic_clear, .dac_power_up, .pb_source, .pb_muted, .pb_gain_target,
    .pb_gain_applied, .pb_gain_stepping, .pb_sample_out);
  task automatic test_done;
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [15:0] e, s);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask : rd
  // one frame strobe pair or sample tick
  task automatic pulse(input logic r, p, t);
    @(posedge clk);
    rec_frame_start <= r;
    pb_frame_start <= p;
    pb_sample_tick <= t;
    @(posedge clk);
    {rec_frame_start, pb_frame_start, pb_sample_tick} <= 3'h0;
    #1;
  endtask : pulse
  task automatic t_reset;
    rd(`CDSV_OFF_RECSEL, 8'h04);
    rd(`CDSV_OFF_MODE, 8'h00);
    rd(`CDSV_OFF_PATH, 8'h14);
    rd(`CDSV_OFF_MUTE, 8'h0C);
    rd(`CDSV_OFF_GAIN, 8'h00);
    chk("source", 16'h0001, pb_source);
    wr(8'h42, 8'hFF);
    rd(8'h42, 8'h00);
  endtask : t_reset
  task automatic t_recsel;
    logic [4:0] c;
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      wr(`CDSV_OFF_RECSEL, {3'h0, c});
      chk("engine", c == 5'h00, rec_use_engine);
      chk("reserved", !(c inside {5'h00, 5'h04, 5'h05, 5'h06, 5'h0A,
        5'h0B, 5'h0C, 5'h10, 5'h11, 5'h12}), rec_sel_reserved);
    end
  endtask : t_recsel
  task automatic t_mode;
    wr(`CDSV_OFF_MODE, 8'h44);
    chk("cond", 16'hA, {rec_cond_a, rec_cond_b, pb_cond_a, pb_cond_b});
    wr(`CDSV_OFF_MODE, 8'h22);
    chk("cond", 16'h5, {rec_cond_a, rec_cond_b, pb_cond_a, pb_cond_b});
    pulse(1'b1, 1'b1, 1'b0);
    chk("clear", 16'h0003, {rec_ic_clear, pb_ic_clear});
    wr(`CDSV_OFF_MODE, 8'h11);
    pulse(1'b1, 1'b1, 1'b0);
    chk("clear", 16'h0000, {rec_ic_clear, pb_ic_clear});
  endtask : t_mode
  task automatic t_path;
    logic [15:0] e [4] = '{16'h0000, 16'h1234, 16'h0F00, 16'h109A};
    wr(`CDSV_OFF_MUTE, 8'h04);
    for (int s = 0; s < 4; s++) begin
      wr(`CDSV_OFF_PATH, {2'h2, s[1:0], 4'h0});
      pulse(1'b0, 1'b0, 1'b1);
      chk("sample", e[s], pb_sample_out);
    end
    wr(`CDSV_OFF_MUTE, 8'h0C);
    pulse(1'b0, 1'b0, 1'b1);
    chk("muted", 16'h0000, pb_sample_out);
    wr(`CDSV_OFF_MUTE, 8'h04);
    wr(`CDSV_OFF_PATH, 8'h30);
    pulse(1'b0, 1'b0, 1'b1);
    chk("off", 16'h0000, pb_sample_out);
  endtask : t_path
  // count ticks until applied gain reaches target
  task automatic run_ticks(output int n);
    n = 0;
    while (pb_gain_stepping === 1'b1 && n < 400) begin
      pulse(1'b0, 1'b0, 1'b1);
      n++;
    end
  endtask : run_ticks
  task automatic t_gain;
    int n;
    wr(`CDSV_OFF_PATH, 8'h94);
    wr(`CDSV_OFF_GAIN, 8'h02);
    pulse(1'b0, 1'b0, 1'b1);
    chk("applied", 16'h0001, pb_gain_applied);
    wr(`CDSV_OFF_GAIN, 8'h81);
    run_ticks(n);
    chk("ticks", 16'h0080, n[15:0]);
    wr(`CDSV_OFF_PATH, 8'h95);
    wr(`CDSV_OFF_GAIN, 8'h85);
    run_ticks(n);
    chk("pair", 16'h0001, n == 7 || n == 8);
    wr(`CDSV_OFF_PATH, 8'h96);
    wr(`CDSV_OFF_GAIN, 8'h30);
    @(posedge clk);
    #1;
    chk("applied", 16'h0030, pb_gain_applied);
  endtask : t_gain
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_recsel;
    t_mode;
    t_path;
    t_gain;
    test_done;
  end
  initial begin
    #200000;
    miscompares++;
    test_done;
  end
endmodule : codec_dsp_select_dac_volume_tb_top
bind cdsv_regs cdsv_regs_chk u_chk (.clk, .rst_b, .wr_en, .addr, .wdata,
  .rec_frame_start, .pb_frame_start, .pb_sample_tick, .rec_use_engine,
  .rec_sel_reserved, .rec_cond_a, .rec_cond_b, .rec_ic_clear, .pb_cond_a,
  .pb_cond_b, .pb_ic_clear, .dac_power_up, .pb_muted, .pb_gain_stepping,
  .rec_block_sel, .pb_source, .pb_gain_target, .pb_gain_applied);
`default_nettype wire
